//--- src/pls_port_led.sv
// front-panel port indicator split logic, top level
// assumes link inputs synchronous to clock_i, button raw
`timescale 1ns/1ps
`include "pls_regs.svh"

module pls_port_led #(
    parameter int unsigned DEBOUNCE_CYCLES = `PLS_DEBOUNCE_CYCLES,
    parameter int unsigned BLINK_HALF_CYCLES = `PLS_BLINK_HALF_CYCLES
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic fixed_split_i,
    input wire logic split_button_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] link_up_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] traffic_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] fault_i,
    output logic [`PLS_NUM_CAGES-1:0] green_o,
    output logic [`PLS_NUM_CAGES-1:0] amber_o,
    output logic [`PLS_STATE_LEDS-1:0] state_led_o
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        pls_pkg::pls_state_e state;
        logic [`PLS_NUM_CAGES-1:0] green;
        logic [`PLS_NUM_CAGES-1:0] amber;
        logic [`PLS_STATE_LEDS-1:0] state_led;
    } pls_top_s;

    pls_top_s s;
    pls_top_s next_s;
    logic press;
    logic blink;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic pls_pkg::pls_link_t one(input int unsigned pos);
        pls_pkg::pls_link_t m;
        m = '0;
        m[pos] = 1'b1;
        return m;
    endfunction : one

    // link types that drive the cage indicator in a given state
    function automatic pls_pkg::pls_link_t sel_mask(
        input pls_pkg::pls_state_e st,
        input logic fixed
    );
        pls_pkg::pls_link_t lanes;
        pls_pkg::pls_link_t m;
        lanes = one(`PLS_LK_FIRST_LANE) | one(`PLS_LK_SECOND_LANE) |
                one(`PLS_LK_THIRD_LANE) | one(`PLS_LK_FOURTH_LANE);
        m = '0;
        if (fixed) begin
            case (st)
                pls_pkg::PLS_ST2: begin
                    m = one(`PLS_LK_FIRST_HALF) |
                        one(`PLS_LK_SECOND_HALF);
                end
                pls_pkg::PLS_ST3: begin
                    m = lanes;
                end
                default: begin
                    m = one(`PLS_LK_FULL);
                end
            endcase
        end else begin
            case (st)
                pls_pkg::PLS_ST0: begin
                    m = '1;
                end
                pls_pkg::PLS_ST1: begin
                    m = one(`PLS_LK_FULL) | one(`PLS_LK_FIRST_HALF) |
                        one(`PLS_LK_FIRST_LANE);
                end
                pls_pkg::PLS_ST2: begin
                    m = one(`PLS_LK_FULL) | one(`PLS_LK_SECOND_HALF) |
                        one(`PLS_LK_SECOND_LANE);
                end
                pls_pkg::PLS_ST3: begin
                    m = one(`PLS_LK_FULL) | one(`PLS_LK_THIRD_LANE);
                end
                pls_pkg::PLS_ST4: begin
                    m = one(`PLS_LK_FULL) | one(`PLS_LK_FOURTH_LANE);
                end
                default: begin
                    m = '1;
                end
            endcase
        end
        return m;
    endfunction : sel_mask

    // cyclic step of the indication state
    function automatic pls_pkg::pls_state_e step(
        input pls_pkg::pls_state_e st,
        input logic fixed
    );
        pls_pkg::pls_state_e n;
        n = pls_pkg::PLS_ST0;
        case (st)
            pls_pkg::PLS_ST0: begin
                n = pls_pkg::PLS_ST1;
            end
            pls_pkg::PLS_ST1: begin
                n = pls_pkg::PLS_ST2;
            end
            pls_pkg::PLS_ST2: begin
                n = pls_pkg::PLS_ST3;
            end
            pls_pkg::PLS_ST3: begin
                n = fixed ? pls_pkg::PLS_ST1 : pls_pkg::PLS_ST4;
            end
            pls_pkg::PLS_ST4: begin
                n = fixed ? pls_pkg::PLS_ST1 : pls_pkg::PLS_ST0;
            end
            default: begin
                n = pls_pkg::PLS_ST0;
            end
        endcase
        return n;
    endfunction : step

    // ****************************************************
    // button and blink timer
    // ****************************************************
    pls_debounce #(
        .HOLD_CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .button_i(split_button_i),
        .press_o(press)
    );

    pls_blink #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .blink_o(blink)
    );

    // ****************************************************
    // next state and indicator decode
    // ****************************************************
    always_comb begin
        pls_pkg::pls_link_t mask;
        pls_pkg::pls_link_t up;
        pls_pkg::pls_link_t busy;
        pls_pkg::pls_link_t bad;
        logic all_state;
        mask = '0;
        up = '0;
        busy = '0;
        bad = '0;
        all_state = 1'b0;
        next_s = s;
        if (press) begin
            next_s.state = step(s.state, fixed_split_i);
        end
        mask = sel_mask(s.state, fixed_split_i);
        all_state = !fixed_split_i && (s.state == pls_pkg::PLS_ST0);
        for (int c = 0; c < `PLS_NUM_CAGES; c++) begin
            up = link_up_i[c*`PLS_LINK_TYPES +: `PLS_LINK_TYPES] & mask;
            busy = traffic_i[c*`PLS_LINK_TYPES +: `PLS_LINK_TYPES] & up;
            bad = fault_i[c*`PLS_LINK_TYPES +: `PLS_LINK_TYPES] & mask;
            // selected sets other than non-fixed ST0 and fixed ST2/ST3 hold one live link, so any-of follows it
            if (all_state || bad == '0) begin
                next_s.amber[c] = 1'b0;
                next_s.green[c] = (up != '0) &&
                    (busy == '0 || blink);
            end else begin
                next_s.green[c] = 1'b0;
                next_s.amber[c] = blink;
            end
        end
        if (fixed_split_i) begin
            next_s.state_led = `PLS_STATE_LED_RESET;
        end else begin
            next_s.state_led = s.state[4:1];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s.state <= pls_pkg::PLS_ST0;
            s.green <= '0;
            s.amber <= '0;
            s.state_led <= `PLS_STATE_LED_RESET;
        end else begin
            s <= next_s;
        end
    end

    // one indicator pair per cage
    assign green_o = s.green;
    assign amber_o = s.amber;
    assign state_led_o = s.state_led;

endmodule : pls_port_led

//--- src/pls_regs.svh
// constants for the port indicator split logic
// assumes a 100 MHz system clock
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH

// ****************************************************
// geometry
// ****************************************************
`define PLS_NUM_CAGES 8
`define PLS_LINK_TYPES 7
`define PLS_STATE_LEDS 4

// ****************************************************
// link type positions within one cage vector
// ****************************************************
`define PLS_LK_FULL 0
`define PLS_LK_FIRST_HALF 1
`define PLS_LK_SECOND_HALF 2
`define PLS_LK_FIRST_LANE 3
`define PLS_LK_SECOND_LANE 4
`define PLS_LK_THIRD_LANE 5
`define PLS_LK_FOURTH_LANE 6

// ****************************************************
// timing
// ****************************************************
`define PLS_CLK_KHZ 100000
`define PLS_DEBOUNCE_MS 20
`define PLS_BLINK_HALF_MS 250
`define PLS_DEBOUNCE_CYCLES (`PLS_DEBOUNCE_MS * `PLS_CLK_KHZ)
`define PLS_BLINK_HALF_CYCLES (`PLS_BLINK_HALF_MS * `PLS_CLK_KHZ)

// ****************************************************
// reset values
// ****************************************************
`define PLS_STATE_LED_RESET 4'h0

`endif

//--- src/pls_pkg.sv
// types for the port indicator split logic
// assumes pls_regs.svh is available on the include path
package pls_pkg;

    // ****************************************************
    // indication state, one-hot
    // ****************************************************
    typedef enum logic [4:0] {
        PLS_ST0 = 5'b0_0001,
        PLS_ST1 = 5'b0_0010,
        PLS_ST2 = 5'b0_0100,
        PLS_ST3 = 5'b0_1000,
        PLS_ST4 = 5'b1_0000
    } pls_state_e;

    typedef logic [6:0] pls_link_t;

endpackage : pls_pkg

//--- src/pls_debounce.sv
// button synchroniser and debouncer, one pulse per press
// assumes a raw active-high button level, any timing
`timescale 1ns/1ps
module pls_debounce #(
    parameter int unsigned HOLD_CYCLES = 32'h001e_8480
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic button_i,
    output logic press_o
);

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic stable;
        logic [31:0] count;
        logic press;
    } pls_deb_s;

    pls_deb_s s;
    pls_deb_s next_s;

    always_comb begin
        next_s = s;
        next_s.sync_a = button_i;
        next_s.sync_b = s.sync_a;
        next_s.press = 1'b0;
        // level must hold for the full window before it is believed
        if (s.sync_b == s.stable) begin
            next_s.count = 32'h0000_0000;
        end else if (s.count >= HOLD_CYCLES - 32'h0000_0001) begin
            next_s.count = 32'h0000_0000;
            next_s.stable = s.sync_b;
            next_s.press = s.sync_b;
        end else begin
            next_s.count = s.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign press_o = s.press;

endmodule : pls_debounce

//--- src/pls_blink.sv
// shared blink timer for all flashing indicators
// assumes one system clock
`timescale 1ns/1ps
module pls_blink #(
    parameter int unsigned HALF_CYCLES = 32'h017d_7840
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    output logic blink_o
);

    typedef struct packed {
        logic [31:0] count;
        logic phase;
    } pls_blink_s;

    pls_blink_s s;
    pls_blink_s next_s;

    always_comb begin
        next_s = s;
        if (s.count >= HALF_CYCLES - 32'h0000_0001) begin
            next_s.count = 32'h0000_0000;
            next_s.phase = ~s.phase;
        end else begin
            next_s.count = s.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign blink_o = s.phase;

endmodule : pls_blink

//--- tb/pls_button_model.sv
// far-side model: a bouncing front-panel button
// assumes go_i pulses once per press, clock_i free running
`timescale 1ns/1ps
module pls_button_model (
    input wire logic clock_i,
    input wire logic go_i,
    output logic button_o
);
    // ****
    // one press: contact bounce, hold, release
    // ****
    initial button_o = 1'b0;
    always @(posedge go_i) begin
        button_o = 1'b1;
        @(negedge clock_i) button_o = 1'b0;
        @(negedge clock_i) button_o = 1'b1;
        repeat (10) @(negedge clock_i);
        button_o = 1'b0;
    end
endmodule : pls_button_model

//--- tb/pls_port_led_properties.sv
// assertions on the port indicator top-level ports
// assumes bind to pls_port_led, single clock domain
`timescale 1ns/1ps
`include "pls_regs.svh"
module pls_port_led_properties #(
    parameter int unsigned DEBOUNCE_CYCLES = 4,
    parameter int unsigned BLINK_HALF_CYCLES = 8
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic fixed_split_i,
    input wire logic split_button_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] link_up_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] traffic_i,
    input wire logic [`PLS_NUM_CAGES*`PLS_LINK_TYPES-1:0] fault_i,
    input wire logic [`PLS_NUM_CAGES-1:0] green_o,
    input wire logic [`PLS_NUM_CAGES-1:0] amber_o,
    input wire logic [`PLS_STATE_LEDS-1:0] state_led_o
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // cycles since the button was last seen high
    logic [7:0] calm;
    logic quiet;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            calm <= 8'h00;
        end else if (split_button_i) begin
            calm <= 8'h00;
        end else if (calm != 8'hff) begin
            calm <= calm + 8'h01;
        end
    end
    // no debounced press can move the state inside the window
    assign quiet = {24'h00_0000, calm} > DEBOUNCE_CYCLES + 32'h0000_0001;
    sequence steady;
        $stable(link_up_i) && $stable(traffic_i) && $stable(fault_i)
            && $stable(state_led_o) && $stable(fixed_split_i)
            && !split_button_i && quiet;
    endsequence
    sequence amber_drop;
        steady ##1 ($fell(amber_o[0]) ##0 steady) ##1 steady [*7];
    endsequence
    reset_clear_a: assert property (
        $rose(resetn_i) |-> state_led_o == 4'h0)
        else $error("state leds not clear after reset");
    colour_excl_a: assert property (
        (green_o & amber_o) == '0)
        else $error("green and amber lit together");
    state_leds_a: assert property (
        $onehot0(state_led_o))
        else $error("more than one state led lit");
    variant_dark_a: assert property (
        $past(fixed_split_i) |-> state_led_o == 4'h0)
        else $error("state leds lit in variant");
    step_wrap_a: assert property (
        !fixed_split_i && !$past(fixed_split_i)
        && !$past(fixed_split_i, 2) && $changed(state_led_o)
        |-> state_led_o == ($past(state_led_o) == 4'h8 ? 4'h0 :
            $past(state_led_o) == 4'h0 ? 4'h1 : $past(state_led_o) << 1))
        else $error("state did not step by one");
    st0_no_amber_a: assert property (
        state_led_o == 4'h0 && !$past(fixed_split_i) |-> amber_o == '0)
        else $error("amber lit in state 0");
    no_link_dark_a: assert property (
        $past(resetn_i) && $past(link_up_i) == '0 && $past(fault_i) == '0
        |-> green_o == '0 && amber_o == '0)
        else $error("indicator lit with no link");
    blink_phase_a: assert property (
        amber_drop |-> !amber_o[0] ##1 (amber_o[0] || $changed(state_led_o)))
        else $error("blink half period wrong");
endmodule : pls_port_led_properties

bind pls_port_led pls_port_led_properties #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) chk (.clock_i, .resetn_i, .fixed_split_i, .split_button_i, .link_up_i,
    .traffic_i, .fault_i, .green_o, .amber_o, .state_led_o);

//--- tb/pls_port_led_bench.sv
// self-checking bench for the port indicator split logic
// assumes pls_port_led, its checker and the button model
`timescale 1ns/1ps
module pls_port_led_bench;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic fixed_i = 1'b0;
    logic go = 1'b0;
    logic btn;
    logic [55:0] up = '0;
    logic [55:0] tr = '0;
    logic [55:0] ft = '0;
    logic [7:0] green;
    logic [7:0] amber;
    logic [3:0] sled;
    integer seed = 32'hfde7;
    int fails = 0;
    int tests_run = 0;
    int st = 0;
    int gc[8];
    int ac[8];
    always #5 clock_i = ~clock_i;
    pls_button_model pm (.clock_i(clock_i), .go_i(go), .button_o(btn));
    pls_port_led #(.DEBOUNCE_CYCLES(4), .BLINK_HALF_CYCLES(8)) dut (
        .clock_i(clock_i), .resetn_i(resetn_i), .fixed_split_i(fixed_i),
        .split_button_i(btn), .link_up_i(up), .traffic_i(tr),
        .fault_i(ft), .green_o(green), .amber_o(amber),
        .state_led_o(sled));
    // ****
    // expectations
    // ****
    function automatic logic [6:0] msk(int s, logic f);
        if (f) return s == 2 ? 7'h06 : s == 3 ? 7'h78 : 7'h01;
        case (s)
            0: return 7'h7f;
            1: return 7'h0b;
            2: return 7'h15;
            3: return 7'h21;
            default: return 7'h41;
        endcase
    endfunction : msk
    function automatic int cls(int s, logic f, logic [6:0] u, t, e);
        logic [6:0] m;
        m = msk(s, f);
        if ((|(e & m)) && (f || s != 0)) return 3;
        if (!(|(u & m))) return 0;
        return (|(t & u & m)) ? 2 : 1;
    endfunction : cls
    function automatic logic fits(int k, int g, int a);
        case (k)
            0: return g == 0 && a == 0;
            1: return g == 20 && a == 0;
            2: return g inside {[1:19]} && a == 0;
            default: return g == 0 && a inside {[1:19]};
        endcase
    endfunction : fits
    task automatic check(logic ok, string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic press();
        logic [3:0] e;
        go = 1'b1;
        @(negedge clock_i) go = 1'b0;
        repeat (30) @(negedge clock_i);
        st = fixed_i ? (st >= 3 ? 1 : st + 1) : (st + 1) % 5;
        e = (st == 0 || fixed_i) ? 4'h0 : 4'h1 << (st - 1);
        check(sled === e, "state leds");
    endtask : press
    task automatic observe();
        int k;
        for (int t = 0; t < 4; t++) begin
            up = t == 0 ? '0 : t == 1 ? '1 :
                56'({$random(seed), $random(seed)} &
                    {$random(seed), $random(seed)});
            tr = 56'({$random(seed), $random(seed)});
            ft = t == 0 ? '0 : t == 1 ? '1 :
                56'({$random(seed), $random(seed)} &
                    {$random(seed), $random(seed)});
            gc = '{default: 0};
            ac = '{default: 0};
            repeat (2) @(negedge clock_i);
            repeat (20) begin
                @(negedge clock_i);
                foreach (gc[c]) begin
                    gc[c] += int'(green[c] === 1'b1);
                    ac[c] += int'(amber[c] === 1'b1);
                end
            end
            foreach (gc[c]) begin
                k = cls(st, fixed_i, up[c*7+:7], tr[c*7+:7], ft[c*7+:7]);
                check(fits(k, gc[c], ac[c]), "cage led");
                check(gc[c] != 20 || ac[c] == 0, "colour");
            end
        end
        $display("test done state %0d variant %0d", st, fixed_i);
    endtask : observe
    // ****
    // main sequence and watchdog
    // ****
    initial begin
        repeat (8) @(negedge clock_i);
        check(green === 8'h00 && amber === 8'h00 && sled === 4'h0,
            "reset outputs");
        resetn_i = 1'b1;
        observe();
        for (int p = 0; p < 5; p++) begin
            press();
            observe();
        end
        fixed_i = 1'b1;
        repeat (2) @(negedge clock_i);
        check(sled === 4'h0, "variant leds");
        observe();
        repeat (5) begin
            press();
            observe();
        end
        complete_run();
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule : pls_port_led_bench
